// [design/kef_device.sv]
/*
  Device end: event queue, readout byte encoding, configuration register
  with sleep and interrupt mode, and the key interrupt.
  Assumes that events arrive through a valid/ready port from the scanner,
  and that the PWM enable and autosleep/autowake requests come from elsewhere.
*/
// The strobed register port was chosen for this implementation.
// Function
// - Low six bits carry key number.
// - Top bit shows whether more entries remain.
// - Bit six set for release, clear press.
// - Keys 62, 63 always top bit one.
// - Empty 0x3f, overflow 0x7f codes.
// - After overflow, remaining events still delivered.
// - Key 63 code 1x111111, reread for more.
// - Key 62 code 1x111110, reread for more.
// - Autorepeat 0x111110, bit six means more.
// - Sleep bit changeable when PWM disabled.
// - PWM enabled blocks all sleep entry.
// - Sleep bit readable, shows current state.
// - Mode zero: interrupt clears when queue empty.
// - Mode one: interrupt clears after queue read.
// - Sleep bit soft-resets key-switch state only.
`timescale 1ns/1ps
module kef_device
  import kef_pkg::*;
(
  input wire logic RST,
  kef_if.device BUS,
  input wire kef_pkg::kef_entry_t EVT_DATA,
  input wire logic EVT_VALID,
  output logic EVT_READY,
  input wire logic PWM_CC_EN,
  input wire logic AUTO_SLEEP,
  input wire logic AUTO_WAKE,
  output logic KEY_SLEEP,
  output logic KEYSW_SOFT_RST
);
  import kef_pkg::*;

  // -------------------------------------------------------------------
  // Input skid buffer
  // -------------------------------------------------------------------
  // Two entries so the scanner sees registered-grade ready and no word is lost.
  kef_entry_t skid_ff [2];
  logic [1:0] skid_cnt_ff;
  logic skid_rd_ff;
  logic skid_wr_ff;
  logic skid_pop;
  logic skid_push;
  logic [KEF_AW:0] count_ff;
  logic ovfl_ff;
  logic irq_ff;
  logic [7:0] cfg_ff;
  logic [7:0] rdata_ff;
  kef_entry_t mem [KEF_DEPTH];
  logic [KEF_AW-1:0] rptr_ff;
  logic [KEF_AW-1:0] wptr_ff;
  logic q_read;
  logic q_full;
  logic q_empty;
  logic q_drop;
  logic mclk;

  assign mclk = BUS.MCLK;
  assign EVT_READY = (skid_cnt_ff != 2'h2);
  assign skid_push = EVT_VALID && EVT_READY;
  assign q_full = (count_ff == KEF_COUNT_FULL);
  assign q_empty = (count_ff == '0);
  // An event is lost only when the queue is full and no entry leaves this cycle.
  assign q_drop = skid_pop && q_full && !(q_read && !ovfl_ff);
  // A queue register read pops the head entry unless the overflow code is pending or the queue is empty.
  assign q_read = BUS.rd && (BUS.addr == KEF_REG_QUEUE);
  // While full, entries beyond capacity are dropped and flagged as overflow.
  assign skid_pop = (skid_cnt_ff != 2'h0);

  always_ff @(posedge mclk) begin
    if (RST) begin
      skid_cnt_ff <= 2'h0;
      skid_rd_ff <= 1'b0;
      skid_wr_ff <= 1'b0;
    end else begin
      if (skid_push) begin
        skid_ff[skid_wr_ff] <= EVT_DATA;
        skid_wr_ff <= ~skid_wr_ff;
      end
      if (skid_pop) begin
        skid_rd_ff <= ~skid_rd_ff;
      end
      skid_cnt_ff <= skid_cnt_ff + {1'b0, skid_push} - {1'b0, skid_pop};
    end
  end

  // -------------------------------------------------------------------
  // Event queue
  // -------------------------------------------------------------------
  // Overflow keeps the held entries so the host can still drain them.
  always_ff @(posedge mclk) begin
    if (RST) begin
      rptr_ff <= '0;
      wptr_ff <= '0;
      count_ff <= '0;
    end else begin
      logic wr_ok;
      logic rd_ok;
      wr_ok = skid_pop && (!q_full || (q_read && !ovfl_ff));
      rd_ok = q_read && !q_empty && !ovfl_ff;
      if (wr_ok) begin
        mem[wptr_ff] <= skid_ff[skid_rd_ff];
        wptr_ff <= wptr_ff + KEF_PTR_ONE;
      end
      if (rd_ok) begin
        rptr_ff <= rptr_ff + KEF_PTR_ONE;
      end
      count_ff <= count_ff + {{KEF_AW{1'b0}}, wr_ok} - {{KEF_AW{1'b0}}, rd_ok};
    end
  end

  // Overflow sets on a dropped event and clears once its code is read.
  // A drop in the clearing cycle wins, so no lost event goes unflagged.
  always_ff @(posedge mclk) begin
    if (RST) begin
      ovfl_ff <= 1'b0;
    end else if (q_drop) begin
      ovfl_ff <= 1'b1;
    end else if (q_read && ovfl_ff) begin
      ovfl_ff <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Readout encoding
  // -------------------------------------------------------------------
  function automatic logic [7:0] kef_encode(input kef_entry_t e, input logic more);
    logic [7:0] b;
    b = {more, e.release_evt, e.key};
    if (e.repeat_evt) begin
      b = more ? KEF_CODE_RPT_MORE : KEF_CODE_RPT_LAST;
    end else if (e.key == KEF_KEY_ALL || e.key == KEF_KEY_62) begin
      b[KEF_BIT_MORE] = 1'b1;
    end
    return b;
  endfunction

  // -------------------------------------------------------------------
  // Register reads
  // -------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (RST) begin
      rdata_ff <= 8'h00;
    end else if (BUS.rd) begin
      if (BUS.addr == KEF_REG_QUEUE) begin
        if (ovfl_ff) begin
          rdata_ff <= KEF_CODE_OVFL;
        end else if (q_empty) begin
          rdata_ff <= KEF_CODE_EMPTY;
        end else begin
          rdata_ff <= kef_encode(mem[rptr_ff], count_ff != KEF_COUNT_ONE);
        end
      end else if (BUS.addr == KEF_REG_CONFIG) begin
        rdata_ff <= cfg_ff;
      end else begin
        rdata_ff <= 8'h00;
      end
    end
  end
  assign BUS.rdata = rdata_ff;

  // -------------------------------------------------------------------
  // Configuration and sleep
  // -------------------------------------------------------------------
  // With PWM enabled, the sleep bit is held at operating mode whatever is asked.
  always_ff @(posedge mclk) begin
    if (RST) begin
      cfg_ff <= KEF_CFG_RESET;
    end else begin
      logic [7:0] c;
      c = cfg_ff;
      if (BUS.wr && BUS.addr == KEF_REG_CONFIG) begin
        c = BUS.wdata & KEF_CFG_WMASK;
      end
      if (AUTO_SLEEP) begin
        c[KEF_CFG_SLEEP] = 1'b0;
      end
      if (AUTO_WAKE) begin
        c[KEF_CFG_SLEEP] = 1'b1;
      end
      if (PWM_CC_EN) begin
        c[KEF_CFG_SLEEP] = 1'b1;
      end
      cfg_ff <= c;
    end
  end
  // Sleep bit low means chip shut down; a write of it resets only scanning.
  assign KEY_SLEEP = !cfg_ff[KEF_CFG_SLEEP];
  assign KEYSW_SOFT_RST = BUS.wr && (BUS.addr == KEF_REG_CONFIG);

  // -------------------------------------------------------------------
  // Key interrupt
  // -------------------------------------------------------------------
  // A new event in the same cycle as a read keeps the interrupt asserted.
  always_ff @(posedge mclk) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else if (skid_pop) begin
      irq_ff <= 1'b1;
    end else if (cfg_ff[KEF_CFG_IRQMODE] && q_read) begin
      irq_ff <= 1'b0;
    end else if (!cfg_ff[KEF_CFG_IRQMODE] && q_empty && !ovfl_ff) begin
      irq_ff <= 1'b0;
    end
  end
  assign BUS.key_irq_out = irq_ff;
endmodule

// [design/kef_host.sv]
/*
  Host end: drains the event queue when asked, rereading after special
  key codes and continuing past overflow, and writes configuration.
  Assumes the device answers reads one cycle after the strobe.
*/
`timescale 1ns/1ps
module kef_host
  import kef_pkg::*;
(
  input wire logic RST,
  kef_if.host BUS,
  input wire logic CFG_WR,
  input wire logic [7:0] CFG_DATA,
  input wire logic DRAIN,
  output logic [7:0] EVT_BYTE,
  output logic EVT_STB,
  output logic BUSY
);
  import kef_pkg::*;
  typedef enum logic [1:0] {KEF_IDLE, KEF_READ, KEF_WAIT, KEF_TAKE} kef_hstate_t;
  kef_hstate_t st_ff;
  logic mclk;
  logic [7:0] b;
  logic more;

  assign mclk = BUS.MCLK;
  assign b = BUS.rdata;
  // Keep reading after overflow and after key 62/63 codes; stop on empty.
  assign more = b[KEF_BIT_MORE] || (b == KEF_CODE_OVFL) || (b == KEF_CODE_RPT_MORE);

  // -------------------------------------------------------------------
  // Drain sequencer
  // -------------------------------------------------------------------
  // Read data is registered by the device, so it is taken one cycle after
  // the strobe cycle; taking it earlier would return the previous answer.
  always_ff @(posedge mclk) begin
    if (RST) begin
      st_ff <= KEF_IDLE;
      BUS.rd <= 1'b0;
      BUS.wr <= 1'b0;
      BUS.addr <= 8'h00;
      BUS.wdata <= 8'h00;
      EVT_BYTE <= 8'h00;
      EVT_STB <= 1'b0;
    end else begin
      BUS.rd <= 1'b0;
      BUS.wr <= 1'b0;
      EVT_STB <= 1'b0;
      case (st_ff)
        KEF_IDLE: begin
          if (CFG_WR) begin
            BUS.wr <= 1'b1;
            BUS.addr <= KEF_REG_CONFIG;
            BUS.wdata <= CFG_DATA;
          end else if (DRAIN || BUS.key_irq_out) begin
            st_ff <= KEF_READ;
          end
        end
        KEF_READ: begin
          BUS.rd <= 1'b1;
          BUS.addr <= KEF_REG_QUEUE;
          st_ff <= KEF_WAIT;
        end
        KEF_WAIT: begin
          st_ff <= KEF_TAKE; // Strobe cycle; the answer stands in the next one.
        end
        KEF_TAKE: begin
          if (b != KEF_CODE_EMPTY) begin
            EVT_BYTE <= b;
            EVT_STB <= 1'b1;
          end
          st_ff <= more ? KEF_READ : KEF_IDLE;
        end
        default: begin
          st_ff <= KEF_IDLE;
        end
      endcase
    end
  end
  assign BUSY = (st_ff != KEF_IDLE);
endmodule

// [design/kef_if.sv]
/*
  Register link between the keypad device and its host controller.
  Assumes one shared clock; the host issues one-cycle strobes and the
  device answers reads with data valid in the following cycle.
*/
`timescale 1ns/1ps
interface kef_if (
  input wire logic MCLK
);
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic key_irq_out;
  modport device (
    input MCLK,
    input addr,
    input wdata,
    input wr,
    input rd,
    output rdata,
    output key_irq_out
  );
  modport host (
    input MCLK,
    output addr,
    output wdata,
    output wr,
    output rd,
    input rdata,
    input key_irq_out
  );
endinterface

// [design/kef_pkg.sv]
/*
  Shared constants for the key event queue readout: register map, readout
  byte layout, special codes and configuration bit positions.
  Assumes both ends are compiled after this package.
*/
package kef_pkg;
  // -------------------------------------------------------------------
  // Register map
  // -------------------------------------------------------------------
  localparam logic [7:0] KEF_REG_QUEUE = 8'h00;
  localparam logic [7:0] KEF_REG_CONFIG = 8'h01;
  // -------------------------------------------------------------------
  // Readout byte layout and special codes
  // -------------------------------------------------------------------
  localparam int KEF_BIT_MORE = 7;
  localparam int KEF_BIT_REL = 6;
  localparam logic [5:0] KEF_KEY_ALL = 6'h3f;
  localparam logic [5:0] KEF_KEY_62 = 6'h3e;
  localparam logic [7:0] KEF_CODE_EMPTY = 8'h3f;
  localparam logic [7:0] KEF_CODE_OVFL = 8'h7f;
  localparam logic [7:0] KEF_CODE_RPT_LAST = 8'h3e;
  localparam logic [7:0] KEF_CODE_RPT_MORE = 8'h7e;
  // -------------------------------------------------------------------
  // Configuration register fields
  // -------------------------------------------------------------------
  localparam int KEF_CFG_SLEEP = 7;
  localparam int KEF_CFG_IRQMODE = 5;
  localparam logic [7:0] KEF_CFG_RESET = 8'h00;
  localparam logic [7:0] KEF_CFG_WMASK = 8'ha0;
  // -------------------------------------------------------------------
  // Queue sizing
  // -------------------------------------------------------------------
  localparam int KEF_DEPTH = 16;
  localparam int KEF_AW = 4;
  localparam logic [KEF_AW:0] KEF_COUNT_ONE = 5'h01;
  localparam logic [KEF_AW:0] KEF_COUNT_FULL = 5'h10;
  localparam logic [KEF_AW-1:0] KEF_PTR_ONE = 4'h1;
  // Queue entry: key number, release flag, autorepeat marker.
  typedef struct packed {
    logic repeat_evt;
    logic release_evt;
    logic [5:0] key;
  } kef_entry_t;
endpackage

// [testbench/kef_chk.sv]
/*
  Concurrent checks of the link between the key queue device and its host.
  Assumes one clock, the device reset RST and the host end's own reset.
*/
`timescale 1ns/1ps
module kef_chk (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic HOST_RST,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic key_irq_out
);
  default clocking cb @(posedge MCLK);
  endclocking
  // ------------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------------
  logic mode_ff;
  logic qread_ff;
  // Shadow of the interrupt mode bit, since reads of it never happen.
  always_ff @(posedge MCLK) begin
    if (RST) begin
      mode_ff <= 1'b0;
    end else if (wr && addr == 8'h01) begin
      mode_ff <= wdata[5];
    end
  end
  // High in the cycle whose rdata answers a queue read.
  always_ff @(posedge MCLK) begin
    qread_ff <= !RST && rd && addr == 8'h00;
  end
  sequence q_rd;
    rd && addr == 8'h00;
  endsequence
  sequence reread_soon;
    ##[1:6] q_rd;
  endsequence
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  a_no_dual_strobe: assert property (disable iff (RST) !(wr && rd))
    else $error("read and write strobes together");
  a_write_single: assert property (disable iff (RST) wr |=> !wr)
    else $error("write strobe longer than one cycle");
  a_read_queue_only: assert property (disable iff (RST) rd |-> addr == 8'h00)
    else $error("host read outside the queue register");
  a_irq_serviced: assert property (disable iff (RST)
    $fell(HOST_RST) && key_irq_out |-> ##[0:8] q_rd)
    else $error("pending interrupt not serviced");
  a_key6x_reread: assert property (disable iff (RST || HOST_RST)
    qread_ff && rdata[7] && rdata[5:1] == 5'h1f |-> reread_soon)
    else $error("no reread after key 62 or 63");
  a_ovfl_reread: assert property (disable iff (RST || HOST_RST)
    qread_ff && rdata == 8'h7f |-> reread_soon)
    else $error("no read after overflow code");
  a_more_holds_irq: assert property (disable iff (RST)
    qread_ff && !mode_ff && rdata[7] && rdata[5:1] != 5'h1f |-> key_irq_out)
    else $error("interrupt dropped while entries remain");
  a_empty_drops_irq: assert property (disable iff (RST)
    qread_ff && !mode_ff && rdata == 8'h3f |-> ##[0:2] !key_irq_out)
    else $error("interrupt kept with empty queue");
  a_mode1_clear: assert property (disable iff (RST)
    qread_ff && mode_ff |-> ##[0:1] !key_irq_out)
    else $error("interrupt not cleared after read");
endmodule

// [testbench/key_event_fifo_readout_tb_top.sv]
/*
  Bench joining both ends over the link, with a queue model of the events.
  Assumes the package, link, both ends and the checker are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module key_event_fifo_readout_tb_top;
  import kef_pkg::*;
  logic MCLK = 1'b0;
  logic RST = 1'b1;
  logic host_hold = 1'b0, evt_valid = 1'b0, pwm = 1'b0, a_sleep = 1'b0, a_wake = 1'b0;
  logic cfg_wr = 1'b0, drain = 1'b0, host_rst, evt_ready, key_sleep, soft_rst, evt_stb, busy;
  logic [7:0] cfg_data = 8'h00, evt_byte, eb;
  kef_entry_t evt_data = 8'h00;
  logic [7:0] ent[$], exp_q[$];
  logic ovf = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  // Clock and the host end's reset, which the bench also uses to stall it.
  always #12.5 MCLK = ~MCLK;
  assign host_rst = RST | host_hold;
  kef_if kef_if_inst (.MCLK(MCLK));
  kef_device kef_device_inst (.RST(RST), .BUS(kef_if_inst.device), .EVT_DATA(evt_data),
    .EVT_VALID(evt_valid), .EVT_READY(evt_ready), .PWM_CC_EN(pwm), .AUTO_SLEEP(a_sleep),
    .AUTO_WAKE(a_wake), .KEY_SLEEP(key_sleep), .KEYSW_SOFT_RST(soft_rst));
  kef_host kef_host_inst (.RST(host_rst), .BUS(kef_if_inst.host), .CFG_WR(cfg_wr),
    .CFG_DATA(cfg_data), .DRAIN(drain), .EVT_BYTE(evt_byte), .EVT_STB(evt_stb), .BUSY(busy));
  kef_chk kef_chk_inst (.MCLK(MCLK), .RST(RST), .HOST_RST(host_rst), .addr(kef_if_inst.addr),
    .wdata(kef_if_inst.wdata), .wr(kef_if_inst.wr), .rd(kef_if_inst.rd),
    .rdata(kef_if_inst.rdata), .key_irq_out(kef_if_inst.key_irq_out));
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task automatic final_report();
    if (num_errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic timeout();
    num_errors++;
    final_report();
  endtask
  // Config write through the host; the soft reset strobe must follow it.
  task automatic cfg_write(input logic [7:0] v, input logic p);
    int k;
    @(posedge MCLK);
    pwm <= p;
    cfg_data <= v;
    cfg_wr <= 1'b1;
    @(posedge MCLK);
    cfg_wr <= 1'b0;
    for (k = 0; k < 8; k++) begin
      @(negedge MCLK);
      if (soft_rst === 1'b1) break;
    end
    `CHK("soft_rst", 1'b1, soft_rst)
    repeat (3) @(negedge MCLK);
    `CHK("key_sleep", ~v[7] & ~p, key_sleep)
  endtask
  task automatic auto(input logic s, input logic w, input logic p, input logic e);
    @(posedge MCLK);
    pwm <= p;
    a_sleep <= s;
    a_wake <= w;
    @(posedge MCLK);
    a_sleep <= 1'b0;
    a_wake <= 1'b0;
    repeat (2) @(negedge MCLK);
    `CHK("key_sleep", e, key_sleep)
  endtask
  // Offers one event and keeps valid up; the model drops it when full.
  task automatic push(input logic [7:0] e);
    int k;
    evt_data <= e;
    evt_valid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(negedge MCLK);
      if (evt_ready === 1'b1) break;
    end
    if (k == 50) timeout();
    @(posedge MCLK);
    if (ent.size() < KEF_DEPTH) ent.push_back(e);
    else ovf = 1'b1;
  endtask
  task automatic wait_idle();
    int k;
    for (k = 0; k < 600; k++) begin
      @(negedge MCLK);
      if (exp_q.size() == 0 && busy === 1'b0) break;
    end
    if (k == 600) timeout();
  endtask
  // Queues n events with the host stalled, then lets it drain in order.
  task automatic batch(input int b, input int n);
    logic [7:0] e;
    logic m;
    cfg_write({2'b10, b[0], 5'h00}, 1'b0);
    @(posedge MCLK);
    host_hold <= 1'b1;
    for (int i = 0; i < n; i++) begin
      e[5:0] = (i == 0) ? 6'h3e + b[1] : $urandom % 64;
      e[6] = $urandom % 2;
      e[7] = ($urandom % 5 == 0);
      push(e);
    end
    evt_valid <= 1'b0;
    repeat (3) @(posedge MCLK);
    if (ovf) exp_q.push_back(KEF_CODE_OVFL);
    ovf = 1'b0;
    while (ent.size() != 0) begin
      e = ent.pop_front();
      m = (ent.size() != 0);
      if (e[7]) exp_q.push_back(m ? KEF_CODE_RPT_MORE : KEF_CODE_RPT_LAST);
      else exp_q.push_back({m | (e[5:1] == 5'h1f), e[6:0]});
    end
    host_hold <= 1'b0;
    wait_idle();
    @(posedge MCLK);
    drain <= 1'b1;
    @(posedge MCLK);
    drain <= 1'b0;
    wait_idle();
  endtask
  // Every strobed byte is matched against the model; the empty code is never strobed.
  always @(negedge MCLK) begin
    if (evt_stb === 1'b1) begin
      eb = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("evt_byte", eb, evt_byte)
    end
  end
  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'hc7ccbdb9));
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    cfg_write(8'h80, 1'b0);
    auto(1'b1, 1'b0, 1'b0, 1'b1);
    auto(1'b0, 1'b1, 1'b0, 1'b0);
    auto(1'b1, 1'b0, 1'b1, 1'b0);
    cfg_write(8'h00, 1'b1);
    for (int b = 0; b < 6; b++) begin
      batch(b, (b == 2) ? 19 : (b == 5) ? 16 : 1 + $urandom % 10);
    end
    final_report();
  end
endmodule
